// ===== src/tcc_core.sv
`timescale 1ns/10ps
module tcc_core (
   input wire logic clock,
   input wire logic rst,
   input wire tcc_pkg::tcc_bus_req_t busReq,
   output logic [7:0] rdData,
   input wire tcc_pkg::tcc_mode_t modes,
   input wire logic paPin,
   output tcc_pkg::tcc_port_t timerPort,
   output logic [7:0] chFlags,
   output logic ovfFlag,
   output logic [1:0] paFlags,
   output logic pa64Tick,
   output logic wakeAllowed
);
   import tcc_pkg::*;

   logic [7:0] modeSel_q, mask_q, data_q, tov_q, sc1_q, chFlags_q;
   logic [7:0] chFlags_d, port_q, port_d, oe_q, oe_d, rdData_q, rdData_d;
   logic [15:0] ctl_q, cnt_q, cnt_d, pa_q, cntInc;
   logic [15:0] cmp_q [CH_HI:CH_LO];
   logic [7:0] match, forceNow, flagClr, flagSet;
   logic [5:0] pre_q, addr;
   logic [2:0] cmpIdx;
   logic [1:0] paSync_q, pulse_acc_flags_q;
   logic ovf_q, paPrev_q, pa64_q, wake_q, wr, rd, waitStop, frzStop;
   logic preRun, cntTick, cntWrHi, cntWrLo, cntWr, ovfEvt, ch7Evt;
   logic ffca, inCmp, paRun, paEdge;

   // bus decode shared by the register, counter, flag and read processes
   assign wr = busReq.wr;
   assign rd = busReq.rd;
   assign addr = busReq.addr;
   assign ffca = sc1_q[SC1_FFCA];
   assign inCmp = (addr >= OFS_CMP_FIRST) && (addr <= OFS_CMP_LAST);
   assign cmpIdx = addr[3:1];

   // run conditions; freeze spares the prescaler so the
   // accumulator keeps its clock while the counter is held
   assign waitStop = modes.waitMode && sc1_q[SC1_SWAI];
   assign frzStop = modes.freezeMode && sc1_q[SC1_SFRZ];
   assign preRun = sc1_q[SC1_ON] && !waitStop;
   assign cntTick = preRun && !frzStop;
   assign paRun = !waitStop;

   // counter writes need the test mode indicator
   assign cntWrHi = wr && (addr == OFS_CNT_HI) && modes.testMode;
   assign cntWrLo = wr && (addr == OFS_CNT_LO) && modes.testMode;
   assign cntWr = cntWrHi || cntWrLo;
   assign cntInc = cnt_q + WORD_ONE;
   assign ovfEvt = cntTick && !cntWr && (cnt_q == WORD_MAX);

   // compare match on the value the counter steps to
   always_comb begin
      match = BYTE_ZERO;
      for (int n = CH_LO; n <= CH_HI; n++) begin
         match[n] = cntTick && !cntWr && modeSel_q[n] &&
                    (cntInc == cmp_q[n]);
      end
   end

   // forced compares exist only in the write cycle
   assign forceNow = (wr && (addr == OFS_FORCE)) ?
                     (busReq.wdata & CH_MASK) : BYTE_ZERO;
   assign ch7Evt = match[CH_HI] || forceNow[CH_HI];

   // pin actions in priority: ch7 override, overflow toggle,
   // forced or real compare, hold
   always_comb begin
      port_d = port_q;
      oe_d = BYTE_ZERO;
      for (int n = CH_LO; n <= CH_HI; n++) begin
         if (ch7Evt && mask_q[n]) begin
            port_d[n] = data_q[n];
         end else if (ovfEvt && tov_q[n] && modeSel_q[n]) begin
            port_d[n] = ~port_q[n];
         end else if (forceNow[n] || match[n]) begin
            port_d[n] = cmp_action(ctl_q[2*n+1 -: 2], port_q[n]);
         end
         oe_d[n] = modeSel_q[n] &&
                   ((ctl_q[2*n+1 -: 2] != ACT_OFF) || mask_q[n]);
      end
   end

   // timer port level and direction, registered for clean outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         port_q <= BYTE_ZERO;
         oe_q <= BYTE_ZERO;
      end else begin
         port_q <= port_d;
         oe_q <= oe_d;
      end
   end

   // channel flags: a flag set in the clearing cycle survives
   always_comb begin
      flagSet = BYTE_ZERO;
      flagClr = BYTE_ZERO;
      for (int n = CH_LO; n <= CH_HI; n++) begin
         flagSet[n] = match[n] && !forceNow[n];
      end
      if (wr && (addr == OFS_FLG1)) begin
         flagClr = busReq.wdata & CH_MASK;
      end
      if (ffca && inCmp && (int'(cmpIdx) >= CH_LO)) begin
         if (rd && !modeSel_q[cmpIdx]) begin
            flagClr[cmpIdx] = 1'b1;
         end
         if (wr && modeSel_q[cmpIdx]) begin
            flagClr[cmpIdx] = 1'b1;
         end
      end
      chFlags_d = ((chFlags_q & ~flagClr) | flagSet) & CH_MASK;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         chFlags_q <= BYTE_ZERO;
      end else begin
         chFlags_q <= chFlags_d;
      end
   end

   // counter overflow flag; fast clear on any counter access
   always_ff @(posedge clock) begin
      if (rst) begin
         ovf_q <= 1'b0;
      end else if (ovfEvt) begin
         ovf_q <= 1'b1;
      end else if (ffca && (rd || wr) &&
                   ((addr == OFS_CNT_HI) || (addr == OFS_CNT_LO))) begin
         ovf_q <= 1'b0;
      end else if (wr && (addr == OFS_FLG2) && busReq.wdata[FLG2_OVF]) begin
         ovf_q <= 1'b0;
      end
   end

   // main counter; steps every clock while running, and a test write
   // does not touch the prescaler, which only feeds the divide-64 tick
   always_comb begin
      cnt_d = cnt_q;
      if (cntWrHi) begin
         cnt_d = {busReq.wdata, cnt_q[7:0]};
      end else if (cntWrLo) begin
         cnt_d = {cnt_q[15:8], busReq.wdata};
      end else if (cntTick) begin
         cnt_d = cntInc;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= WORD_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // prescaler and the divide-64 tick for the accumulator
   always_ff @(posedge clock) begin
      if (rst) begin
         pre_q <= 6'h00;
         pa64_q <= 1'b0;
      end else begin
         if (preRun) begin
            pre_q <= pre_q + PRE_ONE;
         end
         pa64_q <= preRun && (pre_q == PRE_LAST);
      end
   end

   // accumulator pin crosses in from outside the clock domain
   always_ff @(posedge clock) begin
      if (rst) begin
         paSync_q <= 2'b00;
         paPrev_q <= 1'b0;
      end else begin
         paSync_q <= {paSync_q[0], paPin};
         paPrev_q <= paSync_q[1];
      end
   end
   assign paEdge = paSync_q[1] && !paPrev_q;

   // accumulator count and flags; runs in freeze; clears are
   // written first so a set in the same cycle wins bit by bit
   always_ff @(posedge clock) begin
      if (rst) begin
         pa_q <= WORD_ZERO;
         pulse_acc_flags_q <= 2'b00;
      end else begin
         if (wr && (addr == OFS_PA_HI)) begin
            pa_q <= {busReq.wdata, pa_q[7:0]};
         end else if (wr && (addr == OFS_PA_LO)) begin
            pa_q <= {pa_q[15:8], busReq.wdata};
         end else if (paRun && paEdge) begin
            pa_q <= pa_q + WORD_ONE;
         end
         if (ffca && (rd || wr) &&
             ((addr == OFS_PA_HI) || (addr == OFS_PA_LO))) begin
            pulse_acc_flags_q <= 2'b00;
         end else if (wr && (addr == OFS_PA_FLG)) begin
            pulse_acc_flags_q <= pulse_acc_flags_q & ~(busReq.wdata[1:0] & PAF_MASK);
         end
         if (paRun && paEdge) begin
            pulse_acc_flags_q[PAF_EDGE] <= 1'b1;
            if (pa_q == WORD_MAX) begin
               pulse_acc_flags_q[PAF_OVF] <= 1'b1;
            end
         end
      end
   end

   // software written configuration
   always_ff @(posedge clock) begin
      if (rst) begin
         modeSel_q <= BYTE_ZERO;
         mask_q <= BYTE_ZERO;
         data_q <= BYTE_ZERO;
         tov_q <= BYTE_ZERO;
         ctl_q <= WORD_ZERO;
         sc1_q <= BYTE_ZERO;
      end else if (wr) begin
         unique case (addr)
            OFS_MODE: modeSel_q <= busReq.wdata & CH_MASK;
            OFS_MASK: mask_q <= busReq.wdata & CH_MASK;
            OFS_DATA: data_q <= busReq.wdata & CH_MASK;
            OFS_TOV: tov_q <= busReq.wdata & CH_MASK;
            OFS_CTL1: ctl_q[15:8] <= busReq.wdata;
            OFS_CTL2: ctl_q[7:0] <= busReq.wdata & CTL2_MASK;
            OFS_SC1: sc1_q <= busReq.wdata & SC1_MASK;
            default: ;
         endcase
      end
   end

   // compare registers for channels 2..7, high byte at even offset
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int n = CH_LO; n <= CH_HI; n++) begin
            cmp_q[n] <= WORD_ZERO;
         end
      end else if (wr && inCmp && (int'(cmpIdx) >= CH_LO)) begin
         if (!addr[0]) begin
            cmp_q[cmpIdx][15:8] <= busReq.wdata;
         end else begin
            cmp_q[cmpIdx][7:0] <= busReq.wdata;
         end
      end
   end

   // read data one cycle after the strobe; holes read zero
   always_comb begin
      rdData_d = BYTE_ZERO;
      if (rd) begin
         unique case (addr)
            OFS_MODE: rdData_d = modeSel_q;
            OFS_FORCE: rdData_d = BYTE_ZERO;
            OFS_MASK: rdData_d = mask_q;
            OFS_DATA: rdData_d = data_q;
            OFS_CNT_HI: rdData_d = cnt_q[15:8];
            OFS_CNT_LO: rdData_d = cnt_q[7:0];
            OFS_SC1: rdData_d = sc1_q;
            OFS_TOV: rdData_d = tov_q;
            OFS_CTL1: rdData_d = ctl_q[15:8];
            OFS_CTL2: rdData_d = ctl_q[7:0];
            OFS_FLG1: rdData_d = chFlags_q;
            OFS_FLG2: rdData_d = {ovf_q, 7'h00};
            OFS_PA_FLG: rdData_d = {6'h00, pulse_acc_flags_q};
            OFS_PA_HI: rdData_d = pa_q[15:8];
            OFS_PA_LO: rdData_d = pa_q[7:0];
            default: begin
               if (inCmp && (int'(cmpIdx) >= CH_LO)) begin
                  rdData_d = addr[0] ? cmp_q[cmpIdx][7:0] :
                             cmp_q[cmpIdx][15:8];
               end
            end
         endcase
      end
   end

   // read data and wake permission registers
   always_ff @(posedge clock) begin
      if (rst) begin
         rdData_q <= BYTE_ZERO;
         wake_q <= 1'b1;
      end else begin
         rdData_q <= rdData_d;
         wake_q <= !waitStop;
      end
   end

   assign rdData = rdData_q;
   assign timerPort.level = port_q;
   assign timerPort.oe = oe_q;
   assign chFlags = chFlags_q;
   assign ovfFlag = ovf_q;
   assign paFlags = pulse_acc_flags_q;
   assign pa64Tick = pa64_q;
   assign wakeAllowed = wake_q;

   // checks on the block's own behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_force_reads_zero;
      rd && (addr == OFS_FORCE) |=> rdData == BYTE_ZERO;
   endproperty
   a_force_reads_zero: assert property (p_force_reads_zero)
      else $error("force register read not zero");
   property p_force_clears_pin;
      forceNow[5] && !ch7Evt && !ovfEvt &&
      (ctl_q[11:10] == ACT_CLR) |=> !timerPort.level[5];
   endproperty
   a_force_clears_pin: assert property (p_force_clears_pin)
      else $error("forced clear action missing on channel 5");
   property p_ch7_override;
      ch7Evt && mask_q[2] |=> timerPort.level[2] == $past(data_q[2]);
   endproperty
   a_ch7_override: assert property (p_ch7_override)
      else $error("channel 7 override data not on port");
   property p_force_no_flag;
      forceNow[CH_LO] && !chFlags_q[CH_LO] |=> !chFlags[CH_LO];
   endproperty
   a_force_no_flag: assert property (p_force_no_flag)
      else $error("forced compare set a flag");
   property p_mask_oe;
      modeSel_q[4] && mask_q[4] |=> timerPort.oe[4];
   endproperty
   a_mask_oe: assert property (p_mask_oe)
      else $error("masked compare pin not an output");
   property p_count_up;
      cntTick && !cntWr |=> cnt_q == $past(cnt_q) + WORD_ONE;
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("counter did not step up by one");
   property p_write_ignored;
      wr && (addr == OFS_CNT_LO) && !modes.testMode && !cntTick
      |=> cnt_q == $past(cnt_q);
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("counter written outside test mode");
   property p_disabled_holds;
      !sc1_q[SC1_ON] && !cntWr |=> $stable(cnt_q) && !pa64Tick;
   endproperty
   a_disabled_holds: assert property (p_disabled_holds)
      else $error("disabled timer still running");
   property p_no_tick_off;
      !preRun [*2] |=> !pa64Tick;
   endproperty
   a_no_tick_off: assert property (p_no_tick_off)
      else $error("divide-64 tick while inactive");
   property p_wait_stop;
      waitStop && !cntWr && !wr |=> $stable(cnt_q) && $stable(pa_q)
         && !wakeAllowed;
   endproperty
   a_wait_stop: assert property (p_wait_stop)
      else $error("timer ran in wait with stop set");
   property p_ovf_fast_clear;
      ffca && rd && (addr == OFS_CNT_HI) && !ovfEvt |=> !ovfFlag;
   endproperty
   a_ovf_fast_clear: assert property (p_ovf_fast_clear)
      else $error("counter access did not clear overflow");
   property p_pa_fast_clear;
      ffca && rd && ((addr == OFS_PA_HI) || (addr == OFS_PA_LO)) &&
      !(paRun && paEdge) |=> paFlags == 2'b00;
   endproperty
   a_pa_fast_clear: assert property (p_pa_fast_clear)
      else $error("accumulator access did not clear flags");
   c_ch7_override: cover property (ch7Evt && (mask_q != BYTE_ZERO));
   c_force_and_match: cover property (forceNow[CH_LO] && match[CH_LO]);
   c_overflow: cover property (ovfEvt ##1 ovfFlag);
   c_freeze_pa: cover property (frzStop && paRun && paEdge);

endmodule

// ===== src/tcc_pkg.sv
package tcc_pkg;

   // register byte offsets
   localparam logic [5:0] OFS_MODE = 6'h00;
   localparam logic [5:0] OFS_FORCE = 6'h01;
   localparam logic [5:0] OFS_MASK = 6'h02;
   localparam logic [5:0] OFS_DATA = 6'h03;
   localparam logic [5:0] OFS_CNT_HI = 6'h04;
   localparam logic [5:0] OFS_CNT_LO = 6'h05;
   localparam logic [5:0] OFS_SC1 = 6'h06;
   localparam logic [5:0] OFS_TOV = 6'h07;
   localparam logic [5:0] OFS_CTL1 = 6'h08;
   localparam logic [5:0] OFS_CTL2 = 6'h09;
   localparam logic [5:0] OFS_FLG1 = 6'h0e;
   localparam logic [5:0] OFS_FLG2 = 6'h0f;
   localparam logic [5:0] OFS_CMP_FIRST = 6'h10;
   localparam logic [5:0] OFS_CMP_LAST = 6'h1f;
   localparam logic [5:0] OFS_PA_FLG = 6'h21;
   localparam logic [5:0] OFS_PA_HI = 6'h22;
   localparam logic [5:0] OFS_PA_LO = 6'h23;

   // field positions
   localparam int SC1_ON = 7;
   localparam int SC1_SWAI = 6;
   localparam int SC1_SFRZ = 5;
   localparam int SC1_FFCA = 4;
   localparam int FLG2_OVF = 7;
   localparam int PAF_OVF = 1;
   localparam int PAF_EDGE = 0;
   localparam int CH_LO = 2;
   localparam int CH_HI = 7;

   // implemented bits and reset values
   localparam logic [7:0] CH_MASK = 8'hfc;
   localparam logic [7:0] SC1_MASK = 8'hf0;
   localparam logic [7:0] CTL2_MASK = 8'hf0;
   localparam logic [1:0] PAF_MASK = 2'h3;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [15:0] WORD_MAX = 16'hffff;
   localparam logic [15:0] WORD_ONE = 16'h0001;

   // prescaler: divide by 64 for the pulse accumulator clock
   localparam int PRE_DIV = 64;
   localparam logic [5:0] PRE_LAST = 6'(PRE_DIV - 1);
   localparam logic [5:0] PRE_ONE = 6'h01;

   // compare output actions (mode bit, level bit)
   localparam logic [1:0] ACT_OFF = 2'b00;
   localparam logic [1:0] ACT_TOG = 2'b01;
   localparam logic [1:0] ACT_CLR = 2'b10;
   localparam logic [1:0] ACT_SET = 2'b11;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcc_bus_req_t;

   typedef struct packed {
      logic waitMode;
      logic freezeMode;
      logic testMode;
   } tcc_mode_t;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe;
   } tcc_port_t;

   // next pin level for one compare action
   function automatic logic cmp_action(input logic [1:0] act,
                                       input logic cur);
      logic r;
      r = cur;
      unique case (act)
         ACT_OFF: r = cur;
         ACT_TOG: r = ~cur;
         ACT_CLR: r = 1'b0;
         ACT_SET: r = 1'b1;
      endcase
      return r;
   endfunction

endpackage

// ===== verification/tcc_tb.sv
`timescale 1ns/10ps
module tb;
   import tcc_pkg::*;

   typedef struct packed {
      logic [5:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } tcc_row_t;

   logic clock;
   logic rst;
   tcc_bus_req_t busReq;
   logic [7:0] rdData;
   tcc_mode_t modes;
   logic paPin;
   tcc_port_t timerPort;
   logic [7:0] chFlags;
   logic ovfFlag;
   logic [1:0] paFlags;
   logic pa64Tick;
   logic wakeAllowed;
   int failures;
   int comparisons;
   int ticks;
   logic [7:0] v0;
   logic [7:0] v1;

   // register rows: offset, write value, expected read back
   // timer stays off here so the counter holds still
   tcc_row_t rows [13] = '{
      '{OFS_FORCE, 8'hfc, 8'h00},
      '{OFS_MASK, 8'hff, 8'hfc},
      '{OFS_DATA, 8'hff, 8'hfc},
      '{OFS_CNT_HI, 8'h12, 8'h00},
      '{OFS_CNT_LO, 8'h34, 8'h00},
      '{OFS_SC1, 8'h7f, 8'h70},
      '{6'h2a, 8'h55, 8'h00},
      '{OFS_TOV, 8'hff, 8'hfc},
      '{OFS_TOV, 8'h00, 8'h00},
      '{OFS_CTL2, 8'hff, 8'hf0},
      '{OFS_CTL2, 8'h00, 8'h00},
      '{OFS_MODE, 8'hff, 8'hfc},
      '{OFS_MODE, 8'h00, 8'h00}
   };

   tcc_core i_tcc_core (
      .clock(clock),
      .rst(rst),
      .busReq(busReq),
      .rdData(rdData),
      .modes(modes),
      .paPin(paPin),
      .timerPort(timerPort),
      .chFlags(chFlags),
      .ovfFlag(ovfFlag),
      .paFlags(paFlags),
      .pa64Tick(pa64Tick),
      .wakeAllowed(wakeAllowed)
   );

   // 200 MHz clock
   always #2.5 clock = ~clock;

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle write; returns once its effect is visible
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge clock);
      busReq.wr <= 1'b0;
      #1;
   endtask

   // one-cycle read; data only stands in the cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge clock);
      busReq.rd <= 1'b0;
      #1;
      d = rdData;
   endtask

   task automatic count_ticks(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clock);
         #1;
         if (pa64Tick === 1'b1) begin
            c++;
         end
      end
   endtask

   // two low-byte reads two cycles apart give the counter step
   task automatic cnt_step(input string what, input logic [7:0] exp);
      rd(OFS_CNT_LO, v0);
      rd(OFS_CNT_LO, v1);
      check(what, exp, 8'(v1 - v0));
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      tally_and_finish();
   end

   initial begin
      clock = 1'b0;
      rst = 1'b1;
      busReq = '0;
      modes = '0;
      paPin = 1'b0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      check("port after reset", 16'h0000, timerPort);
      check("flags after reset", 8'h00, chFlags);
      check("wake after reset", 1'b1, wakeAllowed);

      // register table
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v0);
         check("readback", rows[i].e, v0);
      end
      @(posedge clock);
      #1;
      check("read data after its cycle", 8'h00, rdData);

      // test mode write, then run into the wrap; ch2 toggles on it
      wr(OFS_SC1, 8'h00);
      wr(OFS_MODE, 8'h04);
      wr(OFS_TOV, 8'h04);
      @(posedge clock);
      modes.testMode <= 1'b1;
      wr(OFS_CNT_HI, 8'hff);
      wr(OFS_CNT_LO, 8'hfe);
      rd(OFS_CNT_HI, v0);
      check("counter high test write", 8'hff, v0);
      rd(OFS_CNT_LO, v0);
      check("counter low test write", 8'hfe, v0);
      @(posedge clock);
      modes.testMode <= 1'b0;
      wr(OFS_SC1, 8'h80);
      for (int i = 0; i < 20 && ovfFlag !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      check("overflow at wrap", 1'b1, ovfFlag);
      check("toggle on overflow", 1'b1, timerPort.level[2]);
      check("match at wrap", 8'h04, chFlags);
      wr(OFS_FLG1, 8'h04);
      check("flag write clear", 8'h00, chFlags);
      rd(OFS_CNT_LO, v0);
      check("overflow kept", 1'b1, ovfFlag);
      wr(OFS_SC1, 8'h90);
      rd(OFS_CNT_HI, v0);
      check("overflow fast clear", 1'b0, ovfFlag);

      // counting, stopping, prescaler tick
      cnt_step("counter runs", 8'h02);
      count_ticks(128, ticks);
      check("ticks running", 16'd2, 16'(ticks));
      wr(OFS_SC1, 8'h10);
      cnt_step("counter off", 8'h00);
      count_ticks(130, ticks);
      check("ticks off", 16'd0, 16'(ticks));

      // wait mode with stop-in-wait
      wr(OFS_SC1, 8'hc0);
      @(posedge clock);
      modes.waitMode <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check("wake in wait stop", 1'b0, wakeAllowed);
      cnt_step("counter wait stop", 8'h00);
      count_ticks(128, ticks);
      check("ticks wait stop", 16'd0, 16'(ticks));
      @(posedge clock);
      modes.waitMode <= 1'b0;

      // freeze mode: counter halts, prescaler keeps going
      wr(OFS_SC1, 8'ha0);
      @(posedge clock);
      modes.freezeMode <= 1'b1;
      repeat (2) @(posedge clock);
      cnt_step("counter freeze", 8'h00);
      count_ticks(128, ticks);
      check("ticks freeze", 16'd2, 16'(ticks));
      @(posedge clock);
      modes.freezeMode <= 1'b0;

      // forced compares: ch6 set, ch5 clear, ch4 toggle, ch3 set, ch2 toggle
      wr(OFS_SC1, 8'h80);
      wr(OFS_MASK, 8'h00);
      wr(OFS_DATA, 8'h00);
      wr(OFS_MODE, 8'hfc);
      wr(OFS_CTL1, 8'h39);
      wr(OFS_CTL2, 8'hd0);
      @(posedge clock);
      #1;
      check("enables by pair", 8'h7c, timerPort.oe);
      wr(OFS_FORCE, 8'h7c);
      check("force levels", 8'h58, timerPort.level);
      wr(OFS_FORCE, 8'h7c);
      check("force toggles back", 8'h4c, timerPort.level);
      check("force leaves flags", 8'h00, chFlags);
      // ch2 disconnected; only the ch7 mask keeps it an output
      wr(OFS_CTL2, 8'hc0);
      @(posedge clock);
      #1;
      check("enable dropped", 8'h78, timerPort.oe);
      wr(OFS_MASK, 8'h44);
      @(posedge clock);
      #1;
      check("enable by mask", 8'h7c, timerPort.oe);
      wr(OFS_DATA, 8'h04);
      // ch6 forced high too, but the masked ch7 data must win
      wr(OFS_FORCE, 8'hc0);
      check("ch7 override", 8'h0c, timerPort.level);
      check("no flag on force", 8'h00, chFlags);

      // real compare on ch5 from a known counter start
      wr(OFS_SC1, 8'h00);
      wr(OFS_MASK, 8'h00);
      @(posedge clock);
      modes.testMode <= 1'b1;
      wr(OFS_CNT_HI, 8'h00);
      wr(OFS_CNT_LO, 8'h00);
      @(posedge clock);
      modes.testMode <= 1'b0;
      wr(OFS_CTL1, 8'h0c);
      wr(6'h1a, 8'h00);
      wr(6'h1b, 8'h10);
      wr(OFS_SC1, 8'h80);
      for (int i = 0; i < 100 && chFlags[5] !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      check("ch5 match flag", 1'b1, chFlags[5]);
      check("ch5 match level", 1'b1, timerPort.level[5]);
      wr(OFS_SC1, 8'h90);
      wr(6'h1b, 8'h20);
      check("ch5 fast clear", 1'b0, chFlags[5]);

      // accumulator edge, then fast clear by count access
      @(posedge clock);
      paPin <= 1'b1;
      repeat (4) @(posedge clock);
      paPin <= 1'b0;
      for (int i = 0; i < 20 && paFlags[0] !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      check("edge flag set", 1'b1, paFlags[0]);
      rd(OFS_PA_HI, v0);
      check("acc flags fast clear", 2'b00, paFlags);

      // reset in mid-run must bring every output back to idle
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      check("port after second reset", 16'h0000, timerPort);
      check("flags after second reset", 8'h00, chFlags);
      check("overflow after second reset", 1'b0, ovfFlag);
      rd(OFS_SC1, v0);
      check("control after second reset", 8'h00, v0);

      tally_and_finish();
   end
endmodule
